// *** rtl/amd_decoder.sv ***
`timescale 1ns/1ps
module amd_decoder
  import amd_pkg::*;
(
  input  wire logic              mclk,         // System clock, 40 MHz.
  input  wire logic              rst,          // Synchronous reset, active high.
  input  wire logic              por,          // Power-on reset, active high.
  input  wire logic              por_wait,     // Step-down stabilisation wait.
  input  wire logic              ext_rst_n,    // External reset pin level, low active.
  input  wire logic [1:0]        variant,      // Variant code.
  input  wire logic [1:0]        mode,         // Memory access mode.
  input  wire logic              mirror_en,    // Mirror function enable.
  input  wire logic              req,          // Core access request.
  input  wire logic [ADDR_W-1:0] addr,         // Core address.
  input  wire logic              cfg_wr,       // Write to power-on-only register.
  input  wire logic [7:0]        cfg_wdata,    // Its data.
  output logic                   hit_q,        // Decoded result valid.
  output logic      [2:0]        target_q,     // Selected target.
  output logic      [ADDR_W-1:0] phys_addr_q,  // Address after mirroring.
  output logic      [ADDR_W-1:0] ext_addr_q,   // External address bus.
  output logic                   ext_en_q,     // External bus cycle.
  output logic                   mirrored_q,   // Access was redirected.
  output logic                   port01_oe_q,  // Port 0/1 output enable.
  output logic      [7:0]        por_reg_q     // Power-on-only register.
);

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  // Region limits follow the variant pins; the evaluation part has the larger
  // RAM and the widest ROM.
  function automatic logic [ADDR_W-1:0] ram_end(input logic [1:0] v);
    ram_end = (v == VAR_EVAL) ? RAM_END_LARGE : RAM_END_SMALL;
  endfunction

  function automatic logic [ADDR_W-1:0] rom_start(input logic [1:0] v);
    if (v == VAR_EVAL) begin
      rom_start = ROM_START_256K;
    end else if (v == VAR_ROM128) begin
      rom_start = ROM_START_128K;
    end else begin
      rom_start = ROM_START_64K;
    end
  endfunction

  // The mirror only ever looks at bank 00, so the bank test and the lower
  // bound together describe the whole window up to the top of the bank.
  function automatic logic in_window(input logic [ADDR_W-1:0] a);
    in_window = (a[ADDR_W-1:OFS_W] == BANK_LOW) && (a >= MIRROR_LO);
  endfunction

  // Ordinary decode when no redirect applies. Mirror-range addresses that
  // reach here fall to the external bus, or to nothing in single-chip mode.
  function automatic logic [2:0] plain_target(input logic [ADDR_W-1:0] a,
                                              input logic [1:0]        v,
                                              input logic [1:0]        m);
    if (a < IO_END) begin
      plain_target = TGT_IO;
    end else if (a < ram_end(v)) begin
      plain_target = TGT_RAM;
    end else if ((m != MODE_EXT_EXT) && (a >= rom_start(v))) begin
      plain_target = TGT_ROM;
    end else if (m != MODE_SINGLE) begin
      plain_target = TGT_EXT;
    end else begin
      plain_target = TGT_NONE;
    end
  endfunction

  // ---------------------------------------------------------------------------
  // Reset sequencing
  // ---------------------------------------------------------------------------
  amd_state_t st_q, st_d;

  // A power-on event or an open stabilisation wait overrides every other
  // transition, so no request can slip through from the second cycle of the wait on.
  always_comb begin
    st_d = st_q;
    case (st_q)
      AMD_ST_POR_WAIT: begin
        if (!por_wait) begin
          st_d = AMD_ST_RESET;
        end
      end
      AMD_ST_RESET: begin
        if (!rst) begin
          st_d = AMD_ST_RUN;
        end
      end
      AMD_ST_RUN: begin
        st_d = AMD_ST_RUN;
      end
      default: begin
        st_d = AMD_ST_POR_WAIT;
      end
    endcase
    if (por || por_wait) begin
      st_d = AMD_ST_POR_WAIT;
    end else if (rst) begin
      st_d = AMD_ST_RESET;
    end
  end

  always_ff @(posedge mclk) begin
    st_q <= st_d;
  end

  // ---------------------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------------------
  logic              hit_d;
  logic [2:0]        target_d;
  logic [ADDR_W-1:0] phys_d;
  logic              ext_en_d;
  logic              mirrored_d;
  logic              rom_int;
  logic              in_mirror;
  logic              clr;

  // A request is only taken in the run state; anything earlier is dropped
  // rather than queued, so the core must wait out the reset sequence.
  always_comb begin
    clr        = rst || por;
    rom_int    = (mode != MODE_EXT_EXT);
    in_mirror  = in_window(addr);
    hit_d      = 1'b0;
    target_d   = TGT_NONE;
    phys_d     = addr;
    ext_en_d   = 1'b0;
    mirrored_d = 1'b0;
    if (!clr && st_q == AMD_ST_RUN && req) begin
      hit_d = 1'b1;
      if (in_mirror && rom_int && mirror_en) begin
        phys_d     = {BANK_ROM, addr[OFS_W-1:0]};
        target_d   = TGT_ROM;
        mirrored_d = 1'b1;
      end else begin
        target_d = plain_target(addr, variant, mode);
      end
      ext_en_d = (target_d == TGT_EXT);
    end
    if (clr) begin
      phys_d = '0;
    end
  end

  // Every decode output is a flop, so the far side sees clean levels for
  // exactly one cycle per accepted request.
  always_ff @(posedge mclk) begin
    hit_q       <= hit_d;
    target_q    <= target_d;
    phys_addr_q <= phys_d;
    ext_en_q    <= ext_en_d;
    mirrored_q  <= mirrored_d;
  end

  // ---------------------------------------------------------------------------
  // External address bus
  // ---------------------------------------------------------------------------
  // The bus keeps its last address between external cycles, so a slow device
  // sees no glitch; the price is one more register of full address width.
  logic [ADDR_W-1:0] ext_addr_d;

  always_comb begin
    ext_addr_d = ext_addr_q;
    if (rst || por) begin
      ext_addr_d = '0;
    end else if (ext_en_d) begin
      ext_addr_d = addr;
    end
  end

  always_ff @(posedge mclk) begin
    ext_addr_q <= ext_addr_d;
  end

  // ---------------------------------------------------------------------------
  // Port 0/1 drive
  // ---------------------------------------------------------------------------
  logic port01_oe_d;

  // The raw wait input is looked at as well as the state, so the output enable follows
  // ext_rst_n (pins float while it is low) from the first clock edge of the wait, not one cycle later.
  always_comb begin
    if (rst || por) begin
      port01_oe_d = 1'b0;
    end else if (por_wait || st_q == AMD_ST_POR_WAIT) begin
      port01_oe_d = ext_rst_n;
    end else begin
      port01_oe_d = (mode != MODE_SINGLE);
    end
  end

  always_ff @(posedge mclk) begin
    port01_oe_q <= port01_oe_d;
  end

  // ---------------------------------------------------------------------------
  // Power-on-only storage
  // ---------------------------------------------------------------------------
  // These bits survive an ordinary reset on purpose; only a fresh power-up
  // brings them back to their initial value.
  amd_por_regs u_por_regs (
    .mclk    (mclk),
    .por     (por),
    .wr_en   (cfg_wr),
    .wr_data (cfg_wdata),
    .reg_q   (por_reg_q)
  );

endmodule

// *** rtl/amd_pkg.sv ***
package amd_pkg;

  // ---------------------------------------------------------------------------
  // Address space
  // ---------------------------------------------------------------------------
  localparam int          ADDR_W          = 24;
  localparam int          OFS_W           = 16;
  localparam logic [7:0]  BANK_LOW        = 8'h00;
  localparam logic [7:0]  BANK_ROM        = 8'hff;
  localparam logic [23:0] IO_END          = 24'h000100;
  localparam logic [23:0] RAM_END_SMALL   = 24'h000900;
  localparam logic [23:0] RAM_END_LARGE   = 24'h001900;
  localparam logic [23:0] MIRROR_LO       = 24'h004000;
  localparam logic [23:0] ROM_START_64K   = 24'hff0000;
  localparam logic [23:0] ROM_START_128K  = 24'hfe0000;
  localparam logic [23:0] ROM_START_256K  = 24'hfc0000;

  // ---------------------------------------------------------------------------
  // Variant and mode codes
  // ---------------------------------------------------------------------------
  localparam logic [1:0]  VAR_ROM64       = 2'h0;
  localparam logic [1:0]  VAR_ROM128      = 2'h1;
  localparam logic [1:0]  VAR_EVAL        = 2'h2;

  localparam logic [1:0]  MODE_SINGLE     = 2'h0;
  localparam logic [1:0]  MODE_INT_EXT    = 2'h1;
  localparam logic [1:0]  MODE_EXT_EXT    = 2'h2;

  localparam logic [2:0]  TGT_NONE        = 3'h0;
  localparam logic [2:0]  TGT_IO          = 3'h1;
  localparam logic [2:0]  TGT_RAM         = 3'h2;
  localparam logic [2:0]  TGT_ROM         = 3'h3;
  localparam logic [2:0]  TGT_EXT         = 3'h4;

  // ---------------------------------------------------------------------------
  // Power-on state
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  POR_REG_INIT    = 8'h00;

  typedef enum logic [2:0] {
    AMD_ST_POR_WAIT = 3'b001,
    AMD_ST_RESET    = 3'b010,
    AMD_ST_RUN      = 3'b100
  } amd_state_t;

endpackage

// *** rtl/amd_por_regs.sv ***
`timescale 1ns/1ps
// Registers cleared only by power-on; other resets leave them alone.
module amd_por_regs
  import amd_pkg::*;
(
  input  wire logic       mclk,        // System clock.
  input  wire logic       por,         // Power-on reset, active high.
  input  wire logic       wr_en,       // Write strobe.
  input  wire logic [7:0] wr_data,     // Write data.
  output logic      [7:0] reg_q        // Held contents.
);

  logic [7:0] reg_d;

  always_comb begin
    reg_d = reg_q;
    if (por) begin
      reg_d = POR_REG_INIT;
    end else if (wr_en) begin
      reg_d = wr_data;
    end
  end

  always_ff @(posedge mclk) begin
    reg_q <= reg_d;
  end

endmodule

// *** test/amd_core_model.sv ***
`timescale 1ns/1ps
module amd_core_model
  import amd_pkg::*;
(
  input  wire logic        mclk, // Clock.
  output logic             req,  // Request.
  output logic      [23:0] addr  // Address.
);
  initial begin
    req = 1'b0;
    addr = 24'h000000;
  end
  // A released address shows its inverse, so a stale value is never mistaken for a live one.
  task automatic issue(input logic [23:0] a);
    @(posedge mclk);
    #1 req = 1'b1;
    addr = a;
    @(posedge mclk);
    #1 req = 1'b0;
    addr = ~a;
  endtask
endmodule

// *** test/amd_decoder_bench.sv ***
`timescale 1ns/1ps
module amd_decoder_bench
  import amd_pkg::*;
;
  logic        mclk = 1'b0;
  logic        rst, por, por_wait, ext_rst_n, mirror_en, cfg_wr, req, hit_q;
  logic        ext_en_q, mirrored_q, port01_oe_q;
  logic [1:0]  variant, mode;
  logic [2:0]  target_q;
  logic [7:0]  cfg_wdata, por_reg_q;
  logic [23:0] addr, phys_addr_q, ext_addr_q;
  int          err_count = 0;
  int          checks = 0;
  int          cycles = 0;
  always #12.5 mclk = ~mclk;
  amd_core_model core (.mclk, .req, .addr);
  amd_decoder DUT (.mclk, .rst, .por, .por_wait, .ext_rst_n, .variant, .mode, .mirror_en,
    .req, .addr, .cfg_wr, .cfg_wdata, .hit_q, .target_q, .phys_addr_q, .ext_addr_q,
    .ext_en_q, .mirrored_q, .port01_oe_q, .por_reg_q);
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 2000) begin
      $display("unexpected cycles expected below %0d seen %0d", 2000, cycles);
      err_count++;
      print_verdict();
    end
  end
  task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
    checks++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", n, e, g);
      err_count++;
    end
  endtask
  task automatic acc(input logic [23:0] a, input logic [2:0] t, input logic m);
    core.issue(a);
    chk("flags", {19'h0, 1'b1, t, m}, {19'h0, hit_q, target_q, mirrored_q});
    chk("phys", m ? {BANK_ROM, a[15:0]} : a, phys_addr_q);
    chk("ext_en", {23'h0, t == TGT_EXT}, {23'h0, ext_en_q});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic t_mirror();
    mode = MODE_INT_EXT;
    mirror_en = 1'b1;
    acc(24'h00c000, TGT_ROM, 1'b1);
    acc(24'h004000, TGT_ROM, 1'b1);
    acc(24'h00ffff, TGT_ROM, 1'b1);
    acc(24'h003fff, TGT_EXT, 1'b0);
    mirror_en = 1'b0;
    acc(24'h00c000, TGT_EXT, 1'b0);
    mirror_en = 1'b1;
    mode = MODE_EXT_EXT;
    acc(24'h00c000, TGT_EXT, 1'b0);
    $display("mirror test done");
  endtask
  task automatic t_modes();
    mode = MODE_SINGLE;
    acc(24'h123456, TGT_NONE, 1'b0);
    chk("port_oe", 24'h0, {23'h0, port01_oe_q});
    mode = MODE_INT_EXT;
    acc(24'h123456, TGT_EXT, 1'b0);
    chk("ext_addr", 24'h123456, ext_addr_q);
    chk("port_oe", 24'h1, {23'h0, port01_oe_q});
    acc(24'h0000ff, TGT_IO, 1'b0);
    chk("ext_addr_hold", 24'h123456, ext_addr_q);
    acc(24'h0008ff, TGT_RAM, 1'b0);
    acc(24'h000900, TGT_EXT, 1'b0);
    acc(24'hfe0000, TGT_EXT, 1'b0);
    variant = VAR_ROM128;
    acc(24'hfe0000, TGT_ROM, 1'b0);
    variant = VAR_EVAL;
    acc(24'h0018ff, TGT_RAM, 1'b0);
    acc(24'hfc0000, TGT_ROM, 1'b0);
    $display("mode test done");
  endtask
  task automatic t_por();
    cfg_wdata = 8'ha5;
    cfg_wr = 1'b1;
    cyc(1);
    cfg_wr = 1'b0;
    rst = 1'b1;
    cyc(1);
    rst = 1'b0;
    cyc(1);
    chk("por_reg", 24'h0000a5, {16'h0, por_reg_q});
    por = 1'b1;
    cyc(1);
    por = 1'b0;
    cyc(1);
    chk("por_reg", 24'h000000, {16'h0, por_reg_q});
    por_wait = 1'b1;
    ext_rst_n = 1'b0;
    core.issue(24'h00c000);
    chk("hit_in_wait", 24'h0, {23'h0, hit_q});
    chk("port_oe_wait", 24'h0, {23'h0, port01_oe_q});
    $display("power-on test done");
  endtask
  task automatic print_verdict();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic t_reset();
    {rst, por, por_wait, ext_rst_n} = 4'he;
    {variant, mode} = {VAR_ROM64, MODE_SINGLE};
    {mirror_en, cfg_wr, cfg_wdata} = 10'h000;
    cyc(2);
    por = 1'b0;
    cyc(4);
    rst = 1'b0;
    cyc(2);
    chk("port_oe", 24'h0, {23'h0, port01_oe_q});
    por_wait = 1'b0;
    ext_rst_n = 1'b1;
    cyc(3);
    $display("reset test done");
  endtask
  initial begin
    t_reset();
    t_mirror();
    t_modes();
    t_por();
    print_verdict();
  end
endmodule

// *** test/amd_decoder_chk.sv ***
`timescale 1ns/1ps
module amd_decoder_chk
  import amd_pkg::*;
(
  input wire logic        mclk,        // Clock.
  input wire logic        rst,         // Reset.
  input wire logic        por,         // Power-on.
  input wire logic        por_wait,    // Wait.
  input wire logic        ext_rst_n,   // Pin.
  input wire logic [1:0]  mode,        // Mode.
  input wire logic        mirror_en,   // Mirror.
  input wire logic        req,         // Request.
  input wire logic [23:0] addr,        // Address.
  input wire logic        cfg_wr,      // Write.
  input wire logic        hit_q,       // Valid.
  input wire logic [2:0]  target_q,    // Target.
  input wire logic [23:0] phys_addr_q, // Physical.
  input wire logic        ext_en_q,    // External.
  input wire logic [23:0] ext_addr_q,  // Bus.
  input wire logic        mirrored_q,  // Redirect.
  input wire logic        port01_oe_q, // Ports.
  input wire logic [7:0]  por_reg_q    // Register.
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst || por);
  AST_HIT: assert property (hit_q |-> $past(req))
    else $error("hit without request");
  AST_MIR: assert property (hit_q && mirrored_q |-> target_q == TGT_ROM &&
    phys_addr_q == (24'hff0000 | ($past(addr) & 24'h00ffff))) else $error("bad mirror");
  AST_WIN: assert property (hit_q && $past(mirror_en) && $past(mode) != MODE_EXT_EXT
    && $past(addr) >= MIRROR_LO && $past(addr) <= 24'h00ffff |-> mirrored_q) else $error("no mirror");
  AST_OFF: assert property (hit_q && (!$past(mirror_en) || $past(mode) == MODE_EXT_EXT)
    |-> !mirrored_q && phys_addr_q == $past(addr)) else $error("mirror when off");
  AST_SGL: assert property (hit_q && $past(mode) == MODE_SINGLE |-> !ext_en_q)
    else $error("external in single");
  AST_EXT: assert property (ext_en_q |-> target_q == TGT_EXT && ext_addr_q == phys_addr_q)
    else $error("bad external address");
  AST_PORT: assert property (por_wait && !ext_rst_n |=> !port01_oe_q)
    else $error("ports driven");
  AST_KEEP: assert property (@(posedge mclk) disable iff (por)
    rst && !cfg_wr |=> por_reg_q == $past(por_reg_q)) else $error("register lost");
  COV_MIR: cover property (hit_q && mirrored_q);
  COV_EXT: cover property (ext_en_q);
  COV_RAM: cover property (hit_q && target_q == TGT_RAM);
endmodule
bind amd_decoder amd_decoder_chk u_chk (.mclk, .rst, .por, .por_wait, .ext_rst_n, .mode,
  .mirror_en, .req, .addr, .cfg_wr, .hit_q, .target_q, .phys_addr_q, .ext_en_q, .ext_addr_q,
  .mirrored_q, .port01_oe_q, .por_reg_q);
